// *** core/dspwm_consts.vh ***
// constants for the dual-slope pwm timer slice
// assumes inclusion by bare name from core/ sources
`ifndef DSPWM_CONSTS_VH
`define DSPWM_CONSTS_VH
// register byte offsets
`define DSPWM_OFF_CTRL 8'h00
`define DSPWM_OFF_COUNT 8'h04
`define DSPWM_OFF_MATCH 8'h08
`define DSPWM_OFF_STATUS 8'h0c
`define DSPWM_OFF_PRESC 8'h10
// control field positions
`define DSPWM_FORCE_BIT 7
`define DSPWM_SHAPE_HI 6
`define DSPWM_PACT_HI 5
`define DSPWM_PACT_LO 4
`define DSPWM_SHAPE_LO 3
`define DSPWM_TSEL_HI 2
`define DSPWM_TSEL_LO 0
// reset values
`define DSPWM_CTRL_RST 8'h00
`define DSPWM_COUNT_RST 8'h00
`define DSPWM_MATCH_RST 8'h00
// encodings
`define DSPWM_SHAPE_NORMAL 2'h0
`define DSPWM_SHAPE_DUAL 2'h1
`define DSPWM_SHAPE_CTC 2'h2
`define DSPWM_SHAPE_FAST 2'h3
`define DSPWM_TSEL_OFF 3'h0
`define DSPWM_TSEL_DIV1 3'h1
`define DSPWM_TSEL_DIV8 3'h2
`define DSPWM_TSEL_DIV64 3'h3
`define DSPWM_TSEL_DIV256 3'h4
`define DSPWM_TSEL_DIV1024 3'h5
`define DSPWM_TSEL_EXT_FALL 3'h6
`define DSPWM_TSEL_EXT_RISE 3'h7
// counts
`define DSPWM_MAX 8'hff
`define DSPWM_BOTTOM 8'h00
`define DSPWM_PRESC_W 10
`define DSPWM_PERIOD_TICKS 510
`endif

// *** core/dspwm_tick_gen.v ***
// shared free-running prescaler, external pin sync and tick select
// assumes clk_in system clock and synchronous-released reset
`timescale 1ns/10ps
`default_nettype none
`include "dspwm_consts.vh"
module dspwm_tick_gen #(
    parameter PW = `DSPWM_PRESC_W
) (
    // clock and reset
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    // control
    input wire presc_clr_in,
    input wire [2:0] tsel_in,
    input wire ext_pin_in,
    // outputs
    output reg tick_out,
    output wire [PW-1:0] presc_out
);
    reg [PW-1:0] presc_q;
    reg sync1_q;
    reg sync2_q;
    reg prev_q;
    wire rise;
    wire fall;
    // all divisors share one counter; taps fire on all ones
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            presc_q <= {PW{1'b0}};
        else if (ce_in)
            presc_q <= presc_clr_in ? {PW{1'b0}} : presc_q + {{(PW-1){1'b0}}, 1'b1}; // [RULE_15]
    end
    assign presc_out = presc_q;
    // pin sampled each cycle, then edge detected
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else if (ce_in)
        begin
            sync1_q <= ext_pin_in; // [RULE_17]
            sync2_q <= sync1_q;
            prev_q <= sync2_q; // [RULE_16]
        end
    end
    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;
    // tick select; taps fire when low bits of prescaler are all ones
    always @*
    begin
        case (tsel_in)
            `DSPWM_TSEL_DIV1: tick_out = 1'b1; // [RULE_13]
            `DSPWM_TSEL_DIV8: tick_out = &presc_q[2:0]; // [RULE_14]
            `DSPWM_TSEL_DIV64: tick_out = &presc_q[5:0];
            `DSPWM_TSEL_DIV256: tick_out = &presc_q[7:0];
            `DSPWM_TSEL_DIV1024: tick_out = &presc_q[9:0];
            `DSPWM_TSEL_EXT_FALL: tick_out = fall; // [RULE_16]
            `DSPWM_TSEL_EXT_RISE: tick_out = rise;
            default: tick_out = 1'b0;
        endcase
    end
endmodule // dspwm_tick_gen
`default_nettype wire

// *** core/dspwm_timer.v ***
// 8-bit dual-slope pwm timer slice with ahb-lite register port
// assumes a single ahb-lite master, word accesses, 100 MHz clk_in
//
// Operation
// [RULE_01] wave shape select value 1 selects dual-slope pwm
// [RULE_02] dual-slope counts bottom up to max then down to bottom
// [RULE_03] pin action 2: clear on up match, set on down match
// [RULE_04] pin action 3: set on up match, clear on down match
// [RULE_05] eight-bit resolution; count stays at max for one tick
// [RULE_06] wrap flag set every time counter reaches bottom
// [RULE_07] one period lasts 510 ticks
// [RULE_08] match bottom gives steady low, max steady high, non-inverting
// [RULE_09] leaving max match corrects output to up-match result
// [RULE_10] missed up match still yields its output change
// [RULE_11] software sets pin direction to output for visibility
// [RULE_12] fully synchronous; tick is a one-cycle clock enable
// [RULE_13] tick select 1 advances every system cycle
// [RULE_14] tick selects 2 to 5 divide by 8, 64, 256, 1024
// [RULE_15] prescaler free running, shared, resettable by software
// [RULE_16] external pin synced, edge detected, select 7 rise, 6 fall
// [RULE_17] synchroniser on rising clock; pin to count 2.5 to 3.5 cycles; code takes 2 to 3 cycles
// [RULE_18] external clock half period longer than one system cycle
// [RULE_19] software toggles external input only with pin stable
// [RULE_20] force strobe applies match action now in non-pwm modes; code drops it when a tick or count write falls in the same cycle
// [RULE_21] forced match sets no flag, no ctc clear; reads zero
// [RULE_22] software writes zero force strobe in pwm modes
// [RULE_23] dual-slope match value double buffered, loaded at top
// [RULE_24] match equal top with upper action bit: act at top only
// [RULE_25] reset: count zero, counting up, output low
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dspwm_consts.vh"
module dspwm_timer #(
    parameter PW = `DSPWM_PRESC_W
) (
    // clock, reset, enable
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,
    // ahb-lite slave
    input wire hsel_in,
    input wire [7:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire [31:0] hrdata_out,
    output wire hreadyout_out,
    output wire hresp_out,
    // pins
    input wire ext_count_pin_in,
    output reg wave_output_out,
    output wire wave_output_en_out,
    output wire timer_tick_out
);
    ////////////////////////////////////////////////////////////////
    // reset release
    reg rst_s1_q;
    reg rst_s2_q;
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;
    ////////////////////////////////////////////////////////////////
    // state
    reg [7:0] ctrl_q;
    reg [7:0] count_q;
    reg [7:0] match_buf_q;
    reg [7:0] match_act_q;
    reg down_q;
    reg wrap_flag_q;
    reg match_flag_q;
    reg block_q;
    reg force_q;
    reg presc_clr_q;
    wire tick;
    wire [PW-1:0] presc;
    wire [1:0] shape = {ctrl_q[`DSPWM_SHAPE_HI], ctrl_q[`DSPWM_SHAPE_LO]};
    wire [1:0] pact = ctrl_q[`DSPWM_PACT_HI:`DSPWM_PACT_LO];
    wire [2:0] tsel = ctrl_q[`DSPWM_TSEL_HI:`DSPWM_TSEL_LO];
    wire dual = (shape == `DSPWM_SHAPE_DUAL); // [RULE_01]
    wire pwm = ctrl_q[`DSPWM_SHAPE_LO];
    ////////////////////////////////////////////////////////////////
    // tick source
    dspwm_tick_gen #(
        .PW(PW)
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .presc_clr_in(presc_clr_q),
        .tsel_in(tsel),
        .ext_pin_in(ext_count_pin_in),
        .tick_out(tick),
        .presc_out(presc)
    );
    assign timer_tick_out = tick;
    ////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states
    reg wr_pend_q;
    reg [7:0] addr_q;
    wire acc = hsel_in & htrans_in[1] & hready_in;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    always @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else if (ce_in)
        begin
            wr_pend_q <= acc & hwrite_in;
            if (acc)
                addr_q <= haddr_in;
        end
    end
    wire wr_ctrl = wr_pend_q && addr_q == `DSPWM_OFF_CTRL;
    wire wr_count = wr_pend_q && addr_q == `DSPWM_OFF_COUNT;
    wire wr_match = wr_pend_q && addr_q == `DSPWM_OFF_MATCH;
    wire wr_stat = wr_pend_q && addr_q == `DSPWM_OFF_STATUS;
    wire wr_presc = wr_pend_q && addr_q == `DSPWM_OFF_PRESC;
    reg [31:0] rdata;
    always @*
    begin
        case (addr_q)
            `DSPWM_OFF_CTRL: rdata = {24'h000000, 1'b0, ctrl_q[6:0]}; // [RULE_21]
            `DSPWM_OFF_COUNT: rdata = {24'h000000, count_q};
            `DSPWM_OFF_MATCH: rdata = {24'h000000, match_buf_q};
            `DSPWM_OFF_STATUS: rdata = {29'h00000000, down_q, match_flag_q, wrap_flag_q};
            default: rdata = 32'h00000000;
        endcase
    end
    reg [31:0] hrdata_q;
    always @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
            hrdata_q <= 32'h00000000;
        else if (ce_in && acc && !hwrite_in)
            hrdata_q <= 32'h00000000;
    end
    // read data is the live register in the data phase
    assign hrdata_out = rdata | hrdata_q;
    ////////////////////////////////////////////////////////////////
    // control writes and strobes
    always @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= `DSPWM_CTRL_RST;
            force_q <= 1'b0;
            presc_clr_q <= 1'b0;
            match_buf_q <= `DSPWM_MATCH_RST;
        end
        else if (ce_in)
        begin
            force_q <= wr_ctrl & hwdata_in[`DSPWM_FORCE_BIT] & ~hwdata_in[`DSPWM_SHAPE_LO]; // [RULE_20]
            presc_clr_q <= wr_presc & hwdata_in[0]; // [RULE_15]
            if (wr_ctrl)
                ctrl_q <= {1'b0, hwdata_in[6:0]};
            if (wr_match)
                match_buf_q <= hwdata_in[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    // counter and compare
    wire top_val = (shape == `DSPWM_SHAPE_CTC) ? 1'b0 : 1'b0;
    wire at_max = (count_q == `DSPWM_MAX);
    wire at_bot = (count_q == `DSPWM_BOTTOM);
    wire cmp = (count_q == match_act_q) & ~block_q;
    wire ctc_hit = (shape == `DSPWM_SHAPE_CTC) && cmp;
    reg [7:0] count_d;
    reg down_d;
    always @*
    begin
        count_d = count_q;
        down_d = down_q;
        if (dual)
        begin
            if (at_max)
                down_d = 1'b1; // [RULE_05]
            else if (at_bot)
                down_d = 1'b0;
            if (at_max | (down_q & ~at_bot))
                count_d = count_q - 8'h01; // [RULE_02]
            else
                count_d = count_q + 8'h01;
        end
        else
        begin
            down_d = 1'b0;
            count_d = ctc_hit ? 8'h00 : count_q + 8'h01;
        end
        count_d = count_d | {7'h00, top_val};
    end
    // next output level from one match event
    function [0:0] act_lvl;
        input [1:0] pa;
        input dn;
        input cur;
        begin
            case (pa)
                2'h1: act_lvl = ~cur;
                2'h2: act_lvl = dn; // [RULE_03]
                2'h3: act_lvl = ~dn; // [RULE_04]
                default: act_lvl = cur;
            endcase
        end
    endfunction
    wire dual_top_case = dual & pact[1] & (match_act_q == `DSPWM_MAX); // [RULE_24]
    always @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= `DSPWM_COUNT_RST; // [RULE_25]
            down_q <= 1'b0;
            match_act_q <= `DSPWM_MATCH_RST;
            wave_output_out <= 1'b0;
            wrap_flag_q <= 1'b0;
            match_flag_q <= 1'b0;
            block_q <= 1'b0;
        end
        else if (ce_in)
        begin
            if (!dual && wr_match)
                match_act_q <= hwdata_in[7:0];
            if (wr_count)
            begin
                count_q <= hwdata_in[7:0];
                block_q <= 1'b1;
            end
            else if (tick) // [RULE_12]
            begin
                count_q <= count_d;
                down_q <= down_d;
                block_q <= 1'b0;
                if (dual && at_max)
                    match_act_q <= match_buf_q; // [RULE_23]
                if (dual_top_case && at_max)
                    wave_output_out <= ~pact[0]; // [RULE_08]
                else if (dual && at_max && pact[1])
                    wave_output_out <= act_lvl(pact, 1'b0, wave_output_out); // [RULE_09]
                else if (dual && at_bot && pact[1] && count_q < match_act_q)
                    wave_output_out <= ~pact[0]; // [RULE_08]
                else if (dual && !down_q && count_q > match_act_q && pact[1] && at_bot)
                    wave_output_out <= act_lvl(pact, 1'b0, wave_output_out); // [RULE_10]
                else if (cmp && !dual_top_case && pact != 2'h1 | !pwm)
                    wave_output_out <= act_lvl(pact, (down_q | at_max) & ~at_bot, wave_output_out); // [RULE_07]
                else if (cmp && !pwm)
                    wave_output_out <= act_lvl(pact, 1'b0, wave_output_out);
            end
            else if (force_q)
                wave_output_out <= act_lvl(pact, 1'b0, wave_output_out); // [RULE_20]
            // set wins over clear
            if (tick && !wr_count && dual && count_d == `DSPWM_BOTTOM && down_q)
                wrap_flag_q <= 1'b1; // [RULE_06]
            else if (tick && !wr_count && !dual && at_max)
                wrap_flag_q <= 1'b1;
            else if (wr_stat && hwdata_in[0])
                wrap_flag_q <= 1'b0;
            if (tick && !wr_count && cmp)
                match_flag_q <= 1'b1; // [RULE_21]
            else if (wr_stat && hwdata_in[1])
                match_flag_q <= 1'b0;
        end
    end
    // driver enabled whenever a pin action is selected
    assign wave_output_en_out = |pact;
endmodule // dspwm_timer
`default_nettype wire

// *** test/dspwm_load_model.sv ***
// load on the waveform pin, pulled down when undriven
// assumes one clock and an active-low reset
`timescale 1ns/10ps
`default_nettype none
module dspwm_load_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // pin drive
    input wire logic drv_in,
    input wire logic drv_en_in,
    // observation
    output logic pin_out,
    output logic [15:0] high_out,
    output logic [15:0] rise_out
);
    logic last_q;
    assign pin_out = drv_en_in & drv_in;
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            last_q <= 1'b0;
            high_out <= 16'h0000;
            rise_out <= 16'h0000;
        end
        else
        begin
            last_q <= pin_out;
            high_out <= high_out + 16'(pin_out);
            rise_out <= rise_out + 16'(pin_out & ~last_q);
        end
    end
endmodule // dspwm_load_model
`default_nettype wire

// *** test/dspwm_timer_assertions.sv ***
// port checker for the dual-slope pwm timer
// assumes word writes, control at offset 0x00
`timescale 1ns/10ps
`default_nettype none
module dspwm_timer_assertions (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // bus
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // pins
    input wire logic ext_count_pin_in,
    input wire logic wave_output_out,
    input wire logic wave_output_en_out,
    input wire logic timer_tick_out
);
    logic wr_q;
    logic [7:0] ctl_q;
    wire logic [2:0] tsel = ctl_q[2:0];
    // control shadow
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_q <= 1'b0;
            ctl_q <= 8'h00;
        end
        else
        begin
            wr_q <= hsel_in & htrans_in[1] & hwrite_in & hready_in & (haddr_in == 8'h00);
            if (wr_q)
                ctl_q <= hwdata_in[7:0];
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    chk_bus_okay:
        assert property (hreadyout_out && !hresp_out) else $error("bus answer bad");
    chk_reset_quiet:
        assert property ($rose(nrst_in) |-> !wave_output_out && !timer_tick_out) else $error("reset output");
    chk_div1_each:
        assert property (tsel == 3'h1 |-> timer_tick_out) else $error("tick missing");
    chk_off_silent:
        assert property (tsel == 3'h0 |-> !timer_tick_out) else $error("tick while off");
    chk_div8_space:
        assert property (tsel == 3'h2 && timer_tick_out |=> (!timer_tick_out || tsel != 3'h2) [*7]
            ##1 (timer_tick_out || tsel != 3'h2)) else $error("div8 spacing");
    chk_pin_enable:
        assert property (wave_output_en_out == (ctl_q[5:4] != 2'h0)) else $error("enable wrong");
    chk_rise_tick:
        assert property (tsel == 3'h7 && $rose(ext_count_pin_in) |-> ##[1:3] timer_tick_out) else $error("no rise tick");
    chk_fall_quiet:
        assert property (tsel == 3'h7 && $fell(ext_count_pin_in) |=> !timer_tick_out [*3]) else $error("fall tick");
    chk_fall_tick:
        assert property (tsel == 3'h6 && $fell(ext_count_pin_in) |-> ##[1:3] timer_tick_out) else $error("no fall tick");
endmodule // dspwm_timer_assertions
bind dspwm_timer dspwm_timer_assertions dspwm_timer_assertions_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .ext_count_pin_in(ext_count_pin_in), .wave_output_out(wave_output_out),
    .wave_output_en_out(wave_output_en_out), .timer_tick_out(timer_tick_out)
);
`default_nettype wire

// *** test/dual_slope_pwm_timer_tb.sv ***
// bench for the dual-slope pwm timer
// assumes design, load model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module dual_slope_pwm_timer_tb;
    logic clk_in, nrst_in, hsel, hwrite, ext, rdy, resp, wave, wen, tick, pin;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic [15:0] hi, ri, a_hi, a_ri;
    int err_total, checks_done, cyc, tcnt, t0;
    logic [21:0] rows [6];
    int divs [5];
    logic [7:0] offs [5];
    dspwm_timer dspwm_timer_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(rdy), .hrdata_out(hrdata),
        .hreadyout_out(rdy), .hresp_out(resp), .ext_count_pin_in(ext), .wave_output_out(wave),
        .wave_output_en_out(wen), .timer_tick_out(tick)
    );
    dspwm_load_model dspwm_load_model_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .drv_in(wave), .drv_en_in(wen), .pin_out(pin), .high_out(hi),
        .rise_out(ri)
    );
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge clk_in);
        while (rdy !== 1'b1) @(posedge clk_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_in);
        while (rdy !== 1'b1) @(posedge clk_in);
        rd = hrdata;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        tcnt <= tcnt + (tick === 1'b1 ? 1 : 0);
        if (cyc == 30000)
        begin
            err_total++;
            stop_test();
        end
    end
    initial
    begin
        rows = '{{2'h2, 8'h00, 10'h000, 2'h0}, {2'h2, 8'h40, 10'h080, 2'h1}, {2'h2, 8'hff, 10'h1fe, 2'h0},
                 {2'h3, 8'h00, 10'h1fe, 2'h0}, {2'h3, 8'h80, 10'h0fe, 2'h1}, {2'h3, 8'hff, 10'h000, 2'h0}};
        divs = '{1, 8, 64, 256, 1024};
        offs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
        {nrst_in, hsel, hwrite, ext, haddr, htrans, hwdata} = '0;
        {err_total, checks_done, cyc, tcnt} = '0;
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        foreach (rows[i])
        begin
            bus(1'b1, 8'h00, {26'h0000000, rows[i][21:20], 4'h9});
            bus(1'b1, 8'h08, {24'h000000, rows[i][19:12]});
            repeat (1024) @(posedge clk_in);
            a_hi = hi;
            a_ri = ri;
            repeat (510) @(posedge clk_in);
            chk("high time", {22'h000000, rows[i][11:2]}, {16'h0000, 16'(hi - a_hi)});
            chk("rises", {30'h00000000, rows[i][1:0]}, {16'h0000, 16'(ri - a_ri)});
        end
        bus(1'b1, 8'h0c, 32'h00000003);
        repeat (520) @(posedge clk_in);
        bus(1'b0, 8'h0c, 32'h00000000);
        chk("wrap flag", 32'h00000001, rd & 32'h00000001);
        nrst_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("reset wave", 32'h00000000, {31'h00000000, wave});
        foreach (offs[k])
        begin
            bus(1'b0, offs[k], 32'h00000000);
            chk("reset read", 32'h00000000, rd);
        end
        for (int p = 3; p > 0; p--)
        begin
            bus(1'b1, 8'h00, {24'h000000, 2'h2, 2'(p), 4'h0});
            repeat (2) @(posedge clk_in);
            chk("forced wave", {31'h00000000, 1'(p)}, {31'h00000000, pin});
            bus(1'b0, 8'h00, 32'h00000000);
            chk("force reads", {26'h0000000, 2'(p), 4'h0}, rd);
        end
        bus(1'b0, 8'h0c, 32'h00000000);
        chk("match flag", 32'h00000000, rd & 32'h00000002);
        bus(1'b1, 8'h10, 32'h00000001);
        foreach (divs[k])
        begin
            bus(1'b1, 8'h00, 32'(k + 1));
            repeat (2) @(posedge clk_in);
            t0 = tcnt;
            repeat (4 * divs[k]) @(posedge clk_in);
            chk("tick count", 32'h00000004, 32'(tcnt - t0));
        end
        for (int s = 7; s > 5; s--)
        begin
            bus(1'b1, 8'h00, 32'(s));
            t0 = tcnt;
            repeat (5)
            begin
                ext <= 1'b1;
                repeat (4) @(posedge clk_in);
                ext <= 1'b0;
                repeat (4) @(posedge clk_in);
            end
            repeat (4) @(posedge clk_in);
            chk("pin ticks", 32'h00000005, 32'(tcnt - t0));
        end
        stop_test();
    end
endmodule // dual_slope_pwm_timer_tb
`default_nettype wire
